// *** hdl/wiper_pkg.sv ***
// constants shared by the serial wiper latch loader and its tap decoder
package wiper_pkg;
    localparam int WORD_BITS           = 10;
    localparam int ADDR_BITS           = 2;
    localparam int CODE_BITS           = 8;
    localparam int TAP_COUNT           = 256;
    localparam int ADDR_MSB            = 9;
    localparam int ADDR_LSB            = 8;
    localparam int CODE_MSB            = 7;
    localparam int CODE_LSB            = 0;
    localparam int MAX_CHANNELS        = 4;
    localparam logic [CODE_BITS-1:0] MIDSCALE_CODE = 8'h80;
    localparam logic [TAP_COUNT-1:0] TAP_LOW_END   = 256'h1;
    localparam logic [TAP_COUNT-1:0] TAP_MIDSCALE  = TAP_LOW_END << MIDSCALE_CODE;
    localparam logic [WORD_BITS-1:0] SHIFT_RESET   = 10'h000;
    // timing
    localparam int CLK_PERIOD_NS       = 10;
    localparam int SCLK_PERIOD_MIN_NS  = 100;
    localparam int SCLK_PERIOD_MIN_CYC =
        (SCLK_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_SAMPLES_MIN    = 4;
endpackage

// *** hdl/wiper_tap_decoder.sv ***
// one-hot wiper tap decode for a single channel, with shutdown handling
`timescale 1ns/1ps
module wiper_tap_decoder
    import wiper_pkg::*;
#(
    parameter int CODE_W = wiper_pkg::CODE_BITS,
    parameter int TAPS   = wiper_pkg::TAP_COUNT
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [CODE_W-1:0] code,
    input  wire logic              active,
    output logic      [TAPS-1:0]   tap_sel,
    output logic                   high_end_connect,
    output logic                   wiper_to_low_end
);
    import wiper_pkg::*;

    if (TAPS != (1 << CODE_W) || TAPS != TAP_COUNT) begin : g_bad_taps
        $error("tap count must equal 2**CODE_W and the package tap count");
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tap_sel <= TAP_MIDSCALE;
        end else if (!active) begin
            tap_sel <= TAP_LOW_END;
        end else begin
            tap_sel <= TAP_LOW_END << code;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_end_connect <= 1'b1;
            wiper_to_low_end <= 1'b0;
        end else begin
            high_end_connect <= active;
            wiper_to_low_end <= !active;
        end
    end

    property p_tap_onehot;
        @(posedge clk) disable iff (!nrst)
        $onehot(tap_sel);
    endproperty
    a_tap_onehot: assert property (p_tap_onehot)
        else $error("wiper tap select is not one-hot");

    property p_tap_zero;
        @(posedge clk) disable iff (!nrst)
        (active && code == 8'h00) |=> tap_sel[0] && !wiper_to_low_end;
    endproperty
    a_tap_zero: assert property (p_tap_zero)
        else $error("code zero did not select the low-end tap");

    property p_tap_step;
        @(posedge clk) disable iff (!nrst)
        (active && $past(active) && code == $past(code) + 8'h01 && code != 8'h00)
            |=> tap_sel == ($past(tap_sel) << 1);
    endproperty
    a_tap_step: assert property (p_tap_step)
        else $error("code step of one did not move the tap by one");

    property p_tap_shutdown;
        @(posedge clk) disable iff (!nrst)
        !active |=> tap_sel == TAP_LOW_END && !high_end_connect && wiper_to_low_end;
    endproperty
    a_tap_shutdown: assert property (p_tap_shutdown)
        else $error("shutdown did not open high end and park wiper at low end");
endmodule

// *** hdl/serial_wiper_latch_loader.sv ***
// serial word capture, channel latches, midscale preset, shutdown and chain output
// Overview of operation
// - one ten-bit serial word carries each channel update
// - word holds two address bits then eight setting bits, msb first
// - target channel index is 2*addr_hi + addr_lo, loaded with bits 7..0
// - words accepted one at a time, any order, only addressed channel changes
// - serial clock up to 10 MHz is supported
// - midscale reset low sets every channel latch to 128
// - shutdown opens high ends and ties each wiper to its low end
// - shutdown keeps latches; release restores the latched settings
// - shutdown keeps shifting and loading but disables chained output
// - writes during shutdown are kept and take effect on release
// - each 8-bit latch selects exactly one of 256 taps
// - code zero selects the low-end tap
// - each code step moves one tap up, up to code 255
// - chip select low shifts one input bit per rising serial clock
// - chip select rising loads setting bits into the addressed latch
// - bit entered ten shifts earlier appears on chained output
// - midscale reset also clears the chained output latch
`timescale 1ns/1ps
module serial_wiper_latch_loader
    import wiper_pkg::*;
#(
    parameter int NUM_CHANNELS = wiper_pkg::MAX_CHANNELS
) (
    input  wire logic                                         clk,
    input  wire logic                                         nrst,
    input  wire logic                                         midscale_reset_n,
    input  wire logic                                         power_down_n,
    input  wire logic                                         chip_select_n,
    input  wire logic                                         serial_clk,
    input  wire logic                                         host_serial_in,
    output logic                                              chain_serial_out,
    output logic                                              chain_serial_out_oe_n,
    output logic [NUM_CHANNELS-1:0][wiper_pkg::CODE_BITS-1:0] wiper_setting_latch,
    output logic [NUM_CHANNELS-1:0][wiper_pkg::TAP_COUNT-1:0] wiper_tap_sel,
    output logic [NUM_CHANNELS-1:0]                           high_end_connect,
    output logic [NUM_CHANNELS-1:0]                           wiper_to_low_end
);
    import wiper_pkg::*;

    if (NUM_CHANNELS != 1 && NUM_CHANNELS != 2 && NUM_CHANNELS != 4) begin : g_bad_ch
        $error("NUM_CHANNELS must be 1, 2 or 4");
    end
    // fastest serial clock must give enough samples per period
    if (SCLK_PERIOD_MIN_CYC < SCLK_SAMPLES_MIN) begin : g_bad_rate
        $error("system clock too slow to sample the serial clock");
    end

    // two-flop synchronisers
    logic sclk_meta;
    logic sclk_s;
    logic sclk_q;
    logic cs_meta;
    logic cs_s;
    logic cs_q;
    logic sdi_meta;
    logic sdi_s;
    logic pd_meta;
    logic pd_s;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_meta <= 1'b0;
            sclk_s    <= 1'b0;
            sclk_q    <= 1'b0;
            cs_meta   <= 1'b1;
            cs_s      <= 1'b1;
            cs_q      <= 1'b1;
            sdi_meta  <= 1'b0;
            sdi_s     <= 1'b0;
            pd_meta   <= 1'b1;
            pd_s      <= 1'b1;
        end else begin
            sclk_meta <= serial_clk;
            sclk_s    <= sclk_meta;
            sclk_q    <= sclk_s;
            cs_meta   <= chip_select_n;
            cs_s      <= cs_meta;
            cs_q      <= cs_s;
            sdi_meta  <= host_serial_in;
            sdi_s     <= sdi_meta;
            pd_meta   <= power_down_n;
            pd_s      <= pd_meta;
        end
    end

    logic shift_evt;
    logic load_evt;
    assign shift_evt = sclk_s && !sclk_q && !cs_s;
    assign load_evt  = cs_s && !cs_q;

    // serial input register
    logic [WORD_BITS-1:0] shift_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= SHIFT_RESET;
        end else if (shift_evt) begin
            shift_reg <= {shift_reg[WORD_BITS-2:0], sdi_s};
        end
    end

    logic                 channel_addr_hi;
    logic                 channel_addr_lo;
    logic [ADDR_BITS-1:0] channel_index;
    logic [CODE_BITS-1:0] channel_code;
    logic                 load_hit;
    assign channel_addr_hi = shift_reg[ADDR_MSB];
    assign channel_addr_lo = shift_reg[ADDR_LSB];
    assign channel_index   = {channel_addr_hi, channel_addr_lo};
    assign channel_code    = shift_reg[CODE_MSB:CODE_LSB];
    // addresses beyond the fitted channels are dropped
    assign load_hit        = load_evt && (32'(channel_index) < NUM_CHANNELS);

    // midscale preset: asserts at once, releases two clocks after the pin
    logic preset_raw_n;
    logic preset_meta_n;
    logic latch_rst_n;
    assign preset_raw_n = nrst && midscale_reset_n;

    always_ff @(posedge clk or negedge preset_raw_n) begin
        if (!preset_raw_n) begin
            preset_meta_n <= 1'b0;
            latch_rst_n   <= 1'b0;
        end else begin
            preset_meta_n <= 1'b1;
            latch_rst_n   <= preset_meta_n;
        end
    end

    // channel latches, preset asynchronously to midscale

    always_ff @(posedge clk or negedge latch_rst_n) begin
        if (!latch_rst_n) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                wiper_setting_latch[i] <= MIDSCALE_CODE;
            end
        end else begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (load_hit && channel_index == ADDR_BITS'(i)) begin
                    wiper_setting_latch[i] <= channel_code;
                end
            end
        end
    end

    // chained output latch: bit falling off the top of the shift register
    logic sdo_bit;

    always_ff @(posedge clk or negedge latch_rst_n) begin
        if (!latch_rst_n) begin
            sdo_bit <= 1'b0;
        end else if (shift_evt) begin
            sdo_bit <= shift_reg[WORD_BITS-1];
        end
    end

    // open drain: only ever pulls low, released in shutdown or when deselected
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chain_serial_out      <= 1'b0;
            chain_serial_out_oe_n <= 1'b1;
        end else begin
            chain_serial_out      <= 1'b0;
            chain_serial_out_oe_n <= !(pd_s && !cs_s && !sdo_bit);
        end
    end

    for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_ch
        wiper_tap_decoder #(
            .CODE_W (CODE_BITS),
            .TAPS   (TAP_COUNT)
        ) u_tap (
            .clk              (clk),
            .nrst             (nrst),
            .code             (wiper_setting_latch[g]),
            .active           (pd_s),
            .tap_sel          (wiper_tap_sel[g]),
            .high_end_connect (high_end_connect[g]),
            .wiper_to_low_end (wiper_to_low_end[g])
        );

        property p_load_target;
            @(posedge clk) disable iff (!latch_rst_n)
            (load_hit && channel_index == ADDR_BITS'(g))
                |=> wiper_setting_latch[g] == $past(channel_code);
        endproperty
        a_load_target: assert property (p_load_target)
            else $error("addressed latch did not take the setting bits");

        property p_load_other;
            @(posedge clk) disable iff (!latch_rst_n)
            !(load_hit && channel_index == ADDR_BITS'(g))
                |=> $stable(wiper_setting_latch[g]);
        endproperty
        a_load_other: assert property (p_load_other)
            else $error("latch changed without being addressed");

        property p_midscale;
            @(posedge clk) disable iff (!nrst)
            !midscale_reset_n |-> wiper_setting_latch[g] == MIDSCALE_CODE;
        endproperty
        a_midscale: assert property (p_midscale)
            else $error("midscale reset did not preset the latch to 128");

        property p_reset_wins;
            @(posedge clk) disable iff (!nrst)
            (!midscale_reset_n && load_hit) |=> !midscale_reset_n
                |-> wiper_setting_latch[g] == MIDSCALE_CODE;
        endproperty
        a_reset_wins: assert property (p_reset_wins)
            else $error("a load overwrote a latch during midscale reset");

        property p_resume;
            @(posedge clk) disable iff (!nrst)
            $rose(pd_s) |=> high_end_connect[g]
                && wiper_tap_sel[g] == (TAP_LOW_END << $past(wiper_setting_latch[g]));
        endproperty
        a_resume: assert property (p_resume)
            else $error("leaving shutdown did not restore the latched setting");

        property p_shutdown_write;
            @(posedge clk) disable iff (!latch_rst_n)
            (!pd_s && load_hit && channel_index == ADDR_BITS'(g))
                |=> wiper_setting_latch[g] == $past(channel_code) && !high_end_connect[g];
        endproperty
        a_shutdown_write: assert property (p_shutdown_write)
            else $error("write in shutdown lost or applied to the wiper early");
    end

    property p_shift;
        @(posedge clk) disable iff (!nrst)
        shift_evt |=> shift_reg == {$past(shift_reg[WORD_BITS-2:0]), $past(sdi_s)};
    endproperty
    a_shift: assert property (p_shift)
        else $error("serial bit not shifted in on clock edge");

    property p_hold;
        @(posedge clk) disable iff (!nrst)
        cs_s |=> $stable(shift_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("shift register moved while deselected");

    property p_chain;
        @(posedge clk) disable iff (!latch_rst_n)
        shift_evt |=> sdo_bit == $past(shift_reg[WORD_BITS-1]);
    endproperty
    a_chain: assert property (p_chain)
        else $error("chained output is not the bit entered ten shifts earlier");

    property p_chain_clear;
        @(posedge clk) disable iff (!nrst)
        !midscale_reset_n |-> !sdo_bit;
    endproperty
    a_chain_clear: assert property (p_chain_clear)
        else $error("midscale reset did not clear the chained output latch");

    property p_chain_off;
        @(posedge clk) disable iff (!nrst)
        !pd_s |=> chain_serial_out_oe_n;
    endproperty
    a_chain_off: assert property (p_chain_off)
        else $error("chained output driven during shutdown");

    property p_shutdown_pins;
        @(posedge clk) disable iff (!nrst)
        !pd_s |=> high_end_connect == '0 && wiper_to_low_end == '1;
    endproperty
    a_shutdown_pins: assert property (p_shutdown_pins)
        else $error("shutdown did not open the high ends");
endmodule

// *** test/serial_host_model.sv ***
// host-side model that shifts serial frames and samples the chained output pin
`timescale 1ns/1ps
module serial_host_model (
    input  wire logic sdo_pin,
    output logic      chip_select_n,
    output logic      serial_clk,
    output logic      host_serial_in
);
    initial begin
        chip_select_n  = 1'b1;
        serial_clk     = 1'b0;
        host_serial_in = 1'b0;
    end

    // twenty bits per frame: the device keeps only the last ten word bits
    task automatic send_frame(input logic [19:0] bits, output logic [9:0] seen);
        seen           = 10'h000;
        host_serial_in = bits[19];
        chip_select_n  = 1'b0;
        #125;
        for (int j = 1; j <= 20; j++) begin
            serial_clk = 1'b1;
            #62.5;
            serial_clk = 1'b0;
            if (j < 20) begin
                host_serial_in = bits[19-j];
            end
            #60;
            if (j > 10) begin
                seen[20-j] = sdo_pin;
            end
            #2.5;
        end
        chip_select_n  = 1'b1;
        // released line shows no stale value
        host_serial_in = ~host_serial_in;
        #250;
    endtask
endmodule

// *** test/tb_serial_wiper_latch_loader.sv ***
// testbench for the serial wiper latch loader
`timescale 1ns/1ps
module tb_serial_wiper_latch_loader;
    import wiper_pkg::*;
    logic                      clk;
    logic                      nrst;
    logic                      midscale_reset_n;
    logic                      power_down_n;
    logic                      chip_select_n;
    logic                      serial_clk;
    logic                      host_serial_in;
    logic                      chain_serial_out;
    logic                      chain_serial_out_oe_n;
    logic                      sdo_pin;
    logic [3:0][CODE_BITS-1:0] wiper_setting_latch;
    logic [3:0][TAP_COUNT-1:0] wiper_tap_sel;
    logic [3:0]                high_end_connect;
    logic [3:0]                wiper_to_low_end;
    logic [CODE_BITS-1:0]      exp_code [4];
    logic [1:0]                ch_tab   [4] = '{2'd3, 2'd0, 2'd2, 2'd1};
    logic [7:0]                code_tab [4] = '{8'h00, 8'hFF, 8'h01, 8'h7F};
    int                        err_total;
    int                        cmp_count;

    // pull-up on the open-drain chain pin
    assign sdo_pin = chain_serial_out_oe_n ? 1'b1 : chain_serial_out;

    serial_wiper_latch_loader #(.NUM_CHANNELS(4)) i_serial_wiper_latch_loader (
        .clk                   (clk),
        .nrst                  (nrst),
        .midscale_reset_n      (midscale_reset_n),
        .power_down_n          (power_down_n),
        .chip_select_n         (chip_select_n),
        .serial_clk            (serial_clk),
        .host_serial_in        (host_serial_in),
        .chain_serial_out      (chain_serial_out),
        .chain_serial_out_oe_n (chain_serial_out_oe_n),
        .wiper_setting_latch   (wiper_setting_latch),
        .wiper_tap_sel         (wiper_tap_sel),
        .high_end_connect      (high_end_connect),
        .wiper_to_low_end      (wiper_to_low_end)
    );

    serial_host_model i_serial_host_model (
        .sdo_pin        (sdo_pin),
        .chip_select_n  (chip_select_n),
        .serial_clk     (serial_clk),
        .host_serial_in (host_serial_in)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [255:0] exp_v, input logic [255:0] got);
        cmp_count++;
        if (got !== exp_v) begin
            $display("unexpected %s expected %h seen %h", what, exp_v, got);
            err_total++;
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_all(input logic pd);
        for (int c = 0; c < 4; c++) begin
            chk("latch", exp_code[c], wiper_setting_latch[c]);
            chk("tap", pd ? TAP_LOW_END : TAP_LOW_END << exp_code[c], wiper_tap_sel[c]);
            chk("high_end", !pd, high_end_connect[c]);
            chk("wiper_low", pd, wiper_to_low_end[c]);
        end
    endtask

    // one frame: ten lead bits for the chain, then the word itself
    task automatic write_word(input logic [1:0] ch, input logic [7:0] code,
                              input logic [9:0] exp_seen, input logic load);
        logic [9:0] seen;
        int         k;
        i_serial_host_model.send_frame({ch, ~code, ch, code}, seen);
        chk("chain", exp_seen, seen);
        if (load) begin
            for (k = 0; k < 20 && wiper_setting_latch[ch] !== code; k++) @(posedge clk);
            if (wiper_setting_latch[ch] !== code) begin
                $display("unexpected latch load expected %h seen %h", code,
                         wiper_setting_latch[ch]);
                err_total++;
                stop_test();
            end
            exp_code[ch] = code;
        end
        wait_clk(6);
    endtask

    initial begin
        nrst             = 1'b0;
        midscale_reset_n = 1'b1;
        power_down_n     = 1'b1;
        err_total        = 0;
        cmp_count        = 0;
        for (int c = 0; c < 4; c++) exp_code[c] = MIDSCALE_CODE;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        wait_clk(4);
        check_all(1'b0);
        for (int i = 0; i < 4; i++) begin
            write_word(ch_tab[i], code_tab[i], {ch_tab[i], ~code_tab[i]}, 1'b1);
            check_all(1'b0);
        end
        @(posedge clk);
        power_down_n <= 1'b0;
        wait_clk(6);
        check_all(1'b1);
        write_word(2'd1, 8'h55, 10'h3FF, 1'b1);
        check_all(1'b1);
        @(posedge clk);
        power_down_n <= 1'b1;
        wait_clk(6);
        check_all(1'b0);
        @(posedge clk);
        midscale_reset_n <= 1'b0;
        for (int c = 0; c < 4; c++) exp_code[c] = MIDSCALE_CODE;
        wait_clk(3);
        check_all(1'b0);
        write_word(2'd2, 8'h33, 10'h000, 1'b0);
        check_all(1'b0);
        @(posedge clk);
        midscale_reset_n <= 1'b1;
        wait_clk(6);
        check_all(1'b0);
        write_word(2'd0, 8'hC3, {2'd0, 8'h3C}, 1'b1);
        check_all(1'b0);
        write_word(2'd0, 8'hC4, {2'd0, 8'h3B}, 1'b1);
        check_all(1'b0);
        stop_test();
    end
endmodule
